// ===== src/lnb_ctl_pkg.sv
package lnb_ctl_pkg;
  localparam int CLK_MHZ = 200;
  // Standard and fast mode bit rates, in kbps
  localparam int STD_KBPS = 100;
  localparam int FAST_KBPS = 400;
  // Master divider: four phases per bit at the fast rate
  localparam int QTR_CYC = (CLK_MHZ * 1000) / (FAST_KBPS * 4);
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] DEV_ADDR_HI = 5'h02;
  localparam int SEL_MSB = 7;
  localparam int SEL_LSB = 5;
  localparam int ST_OVER_TEMP = 4;
  localparam int ST_CABLE = 3;
  localparam int ST_VRANGE = 2;
  localparam int ST_OVERLOAD = 1;
  localparam int ST_BACK = 0;
  localparam logic [4:0] ST_MASK_A = 5'h1f;
  localparam logic [4:0] ST_MASK_B = 5'h0f;
  localparam int TONE_EN = 4;
  localparam int TONE_SRC = 3;
  localparam int DEC_TH = 2;
  localparam int LIM_STATIC = 4;
  localparam int PIN_SEL_DIS = 3;
  localparam int LIM_RANGE = 2;
  localparam int LIM_HIGH = 1;
  localparam int LIM_LOW = 0;
  localparam int OUT_ON = 4;
  localparam int HI_RANGE = 1;
  localparam int LO_RANGE = 0;
  localparam logic [1:0] V13_3 = 2'h0;
  localparam logic [1:0] V14_3 = 2'h1;
  localparam logic [1:0] V18_3 = 2'h2;
  localparam logic [1:0] V19_3 = 2'h3;
  localparam logic [2:0] LIM_275 = 3'h0;
  localparam logic [2:0] LIM_350 = 3'h1;
  localparam logic [2:0] LIM_515 = 3'h2;
  localparam logic [2:0] LIM_635 = 3'h3;
  localparam logic [2:0] LIM_800 = 3'h4;
  localparam logic [2:0] LIM_STAT = 3'h7;
  localparam logic [1:0] TONE_GATED = 2'h0;
  localparam logic [1:0] TONE_EXT = 2'h1;
  localparam logic [1:0] TONE_CONT = 2'h2;
endpackage

// ===== src/lnb_link_if.sv
interface lnb_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));
  modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
  modport host (input scl, input sda, output scl_m_o, output scl_m_oe,
                output sda_m_o, output sda_m_oe);
endinterface

// ===== src/lnb_ctl_dev.sv
// Notes on behaviour
// RL1: Pin enabled: pin picks range, bit picks step
// RL2: Pin disabled: two bits pick four voltages
// RL3: Start is data falling while clock high
// RL4: Stop is data rising while clock high
// RL5: Data changes only while clock low
// RL6: Eight bits, MSB first, then acknowledge
// RL7: Addressed device pulls ninth pulse low
// RL8: No acknowledge while power-good low
// RL9: Address 0001 00XX, LSB one reads
// RL10: Master sends start, address, data, stop
// RL11: Stop always precedes a new start
// RL12: Rates up to 100 and 400 kbps
// RL13: Open-drain only, lines idle high
// RL14: Top three written bits select register
// RL15: All registers clear at power-on
// RL16: Status bits ignore writes
// RL17: Overload and back-current flags follow faults
// RL18: Cable-open flag follows load current
// RL19: Voltage flag follows range fault
// RL20: Over-temperature flag, power blocks disabled
// RL21: Tone bits pick gated, external, continuous
// RL22: Threshold bit picks decoder threshold
// RL23: Static bit off selects dynamic limit
// RL24: Read returns last selected register
module lnb_ctl_dev (
  input wire logic clk,
  input wire logic rst_b,
  lnb_link_if.device link,
  input wire logic power_good,
  input wire logic range_pin_a,
  input wire logic range_pin_b,
  input wire logic modulation_pin_a,
  input wire logic modulation_pin_b,
  input wire logic [4:0] status_a,
  input wire logic [3:0] status_b,
  output logic [1:0] vout_sel_a,
  output logic [1:0] vout_sel_b,
  output logic channel_a_on,
  output logic channel_b_on,
  output logic [1:0] tone_mode_a,
  output logic [1:0] tone_mode_b,
  output logic tone_gate_a,
  output logic tone_gate_b,
  output logic decoder_threshold_a,
  output logic decoder_threshold_b,
  output logic [2:0] limit_sel_a,
  output logic [2:0] limit_sel_b,
  output logic power_off_a,
  output logic power_off_b
);
  import lnb_ctl_pkg::*;

  typedef enum logic [2:0] {IDLE, ADDR, ADDR_ACK, WDATA, WDATA_ACK, RDATA, RDATA_ACK,
                            IGNORE} dev_state_e;

  logic [7:0] regs_r [8];
  logic [2:0] sel_r;
  logic [1:0] scl_s_r, sda_s_r;
  logic [6:0] in_s_r;
  logic [6:0] in_m_r;
  logic scl_d_r, sda_d_r;
  logic [6:0] inp_nxt;
  dev_state_e state_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ack_r;

  // Two-stage sync of pins, then one history stage for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      in_s_r <= 7'h00;
      in_m_r <= 7'h00;
    end else begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      in_s_r <= inp_nxt;
      in_m_r <= in_s_r;
    end
  end
  assign inp_nxt = {power_good, range_pin_a, range_pin_b, modulation_pin_a,
                    modulation_pin_b, 2'h0};

  wire scl_q = scl_s_r[1];
  wire sda_q = sda_s_r[1];
  wire start_ev = scl_q && scl_d_r && sda_d_r && !sda_q; // RL3
  wire stop_ev = scl_q && scl_d_r && !sda_d_r && sda_q; // RL4
  wire scl_rise = scl_q && !scl_d_r; // RL5
  wire scl_fall = !scl_q && scl_d_r;
  wire pgood = in_m_r[6];

  function automatic logic [7:0] read_byte(input logic [2:0] idx, input logic [7:0] r,
                                           input logic [4:0] sa, input logic [3:0] sb);
    logic [7:0] v;
    v = r;
    if (idx == 3'h0) v[4:0] = sa & ST_MASK_A; // RL17 RL18 RL19 RL20
    if (idx == 3'h4) v[4:0] = {1'b0, sb & ST_MASK_B[3:0]};
    return v;
  endfunction

  // Protocol engine; data sampled on rising clock, driven after falling
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= ADDR;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
    end else if (stop_ev) begin
      state_r <= IDLE;
      ack_r <= 1'b0;
    end else begin
      unique case (state_r)
        IDLE, IGNORE: ack_r <= 1'b0;
        ADDR, WDATA: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_q}; // RL6
            bit_r <= bit_r + 4'h1;
          end
          if (scl_fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
            if (state_r == ADDR) begin
              if (sh_r[7:2] == {DEV_ADDR_HI, 1'b0} && pgood) begin // RL9 RL8
                state_r <= ADDR_ACK;
                ack_r <= 1'b1; // RL7
              end else begin
                state_r <= IGNORE;
              end
            end else begin
              state_r <= WDATA_ACK;
              ack_r <= pgood; // RL8
            end
          end
        end
        ADDR_ACK, WDATA_ACK: begin
          if (scl_fall) begin
            ack_r <= 1'b0;
            if (state_r == ADDR_ACK && sh_r[0]) begin
              state_r <= RDATA;
              sh_r <= read_byte(sel_r, regs_r[sel_r], status_a, status_b); // RL24
              bit_r <= 4'h1;
            end else begin
              state_r <= WDATA; // RL6
            end
          end
        end
        RDATA: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              state_r <= RDATA_ACK;
            end else begin
              sh_r <= {sh_r[6:0], 1'b1};
              bit_r <= bit_r + 4'h1;
            end
          end
        end
        RDATA_ACK: begin
          if (scl_rise && sda_q) begin
            state_r <= IGNORE;
          end else if (scl_fall) begin
            // Master acknowledged; next byte's first bit goes out on this fall
            state_r <= RDATA;
            sh_r <= read_byte(sel_r, regs_r[sel_r], status_a, status_b); // RL6
            bit_r <= 4'h1;
          end
        end
      endcase
    end
  end

  // Release the line unless driving a zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.sda_d_oe <= 1'b0;
      link.sda_d_o <= 1'b0;
    end else begin
      link.sda_d_o <= 1'b0;
      link.sda_d_oe <= ack_r || (state_r == RDATA && bit_r != 4'h0 && !sh_r[7]); // RL13 RL7
    end
  end

  wire wr_take = state_r == WDATA && scl_fall && bit_r == 4'h8 && pgood;

  // Register writes; status bits never take written values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 8; i++) regs_r[i] <= REG_RESET; // RL15
      sel_r <= 3'h0;
    end else if (wr_take) begin
      sel_r <= sh_r[SEL_MSB:SEL_LSB]; // RL14
      if (sh_r[SEL_MSB:SEL_LSB] == 3'h0 || sh_r[SEL_MSB:SEL_LSB] == 3'h4) begin
        regs_r[sh_r[SEL_MSB:SEL_LSB]] <= {sh_r[7:5], 5'h00}; // RL16
      end else begin
        regs_r[sh_r[SEL_MSB:SEL_LSB]] <= sh_r;
      end
    end
  end

  function automatic logic [1:0] vsel(input logic [7:0] lim, input logic [7:0] outc,
                                      input logic pin);
    if (lim[PIN_SEL_DIS]) return {outc[HI_RANGE], outc[LO_RANGE]}; // RL2
    return pin ? {1'b1, outc[HI_RANGE]} : {1'b0, outc[LO_RANGE]}; // RL1
  endfunction

  function automatic logic [2:0] lsel(input logic [7:0] lim);
    if (lim[LIM_STATIC]) return LIM_STAT; // RL23
    if (!lim[LIM_RANGE]) return LIM_275;
    return 3'(LIM_350 + {1'b0, lim[LIM_HIGH], lim[LIM_LOW]});
  endfunction

  function automatic logic [1:0] tmode(input logic [7:0] t);
    if (t[TONE_EN]) return TONE_CONT; // RL21
    return t[TONE_SRC] ? TONE_EXT : TONE_GATED;
  endfunction

  // Decoded control outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vout_sel_a <= V13_3;
      vout_sel_b <= V13_3;
      channel_a_on <= 1'b0;
      channel_b_on <= 1'b0;
      tone_mode_a <= TONE_GATED;
      tone_mode_b <= TONE_GATED;
      tone_gate_a <= 1'b0;
      tone_gate_b <= 1'b0;
      decoder_threshold_a <= 1'b0;
      decoder_threshold_b <= 1'b0;
      limit_sel_a <= LIM_275;
      limit_sel_b <= LIM_275;
      power_off_a <= 1'b0;
      power_off_b <= 1'b0;
    end else begin
      vout_sel_a <= vsel(regs_r[2], regs_r[3], in_m_r[5]);
      vout_sel_b <= vsel(regs_r[6], regs_r[7], in_m_r[4]);
      channel_a_on <= regs_r[3][OUT_ON];
      channel_b_on <= regs_r[7][OUT_ON];
      tone_mode_a <= tmode(regs_r[1]);
      tone_mode_b <= tmode(regs_r[5]);
      tone_gate_a <= regs_r[1][TONE_EN] || (!regs_r[1][TONE_SRC] && in_m_r[3]); // RL21
      tone_gate_b <= regs_r[5][TONE_EN] || (!regs_r[5][TONE_SRC] && in_m_r[2]);
      decoder_threshold_a <= regs_r[1][DEC_TH]; // RL22
      decoder_threshold_b <= regs_r[5][DEC_TH];
      limit_sel_a <= lsel(regs_r[2]);
      limit_sel_b <= lsel(regs_r[6]);
      power_off_a <= status_a[ST_OVER_TEMP] || !regs_r[3][OUT_ON]; // RL20
      power_off_b <= status_a[ST_OVER_TEMP] || !regs_r[7][OUT_ON];
    end
  end
endmodule

// ===== src/lnb_ctl_host.sv
module lnb_ctl_host (
  input wire logic clk,
  input wire logic rst_b,
  lnb_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  import lnb_ctl_pkg::*;

  // Registers: 0 command (W: bit0 go, bit1 read, bits3:2 address low),
  // 1 byte to send, 2 status (bit0 busy, bit1 nack), 3 byte received
  localparam logic [1:0] R_CMD = 2'h0;
  localparam logic [1:0] R_TX = 2'h1;
  localparam logic [1:0] R_STAT = 2'h2;
  localparam logic [1:0] R_RX = 2'h3;

  typedef enum logic [2:0] {H_IDLE, H_START, H_BITS, H_STOP} host_state_e;
  host_state_e st_r;
  logic [1:0] ph_r;
  logic [7:0] qc_r;
  logic [4:0] bitn_r;
  logic [17:0] sh_r;
  logic rdop_r, nack_r;
  logic [7:0] tx_r, rx_r;
  logic [1:0] al_r;
  logic [1:0] sda_s_r;
  wire tick = qc_r == 8'(QTR_CYC - 1); // RL12

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) sda_s_r <= 2'h3;
    else sda_s_r <= {sda_s_r[0], link.sda};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rdata <= 8'h00;
    else if (rd) begin
      unique case (addr)
        R_STAT: rdata <= {6'h00, nack_r, st_r != H_IDLE};
        R_RX: rdata <= rx_r;
        R_TX: rdata <= tx_r;
        R_CMD: rdata <= {4'h0, al_r, rdop_r, 1'b0};
      endcase
    end
  end

  // Framing: start, address+ack, one byte+ack, stop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= H_IDLE; ph_r <= 2'h0; qc_r <= 8'h00; bitn_r <= 5'h00;
      sh_r <= 18'h3ffff; rdop_r <= 1'b0; nack_r <= 1'b0; tx_r <= 8'h00;
      rx_r <= 8'h00; al_r <= 2'h0;
      link.scl_m_o <= 1'b1; link.scl_m_oe <= 1'b0;
      link.sda_m_o <= 1'b1; link.sda_m_oe <= 1'b0;
    end else begin
      qc_r <= (st_r == H_IDLE || tick) ? 8'h00 : qc_r + 8'h01;
      if (wr && addr == R_TX) tx_r <= wdata;
      unique case (st_r)
        H_IDLE: if (wr && addr == R_CMD && wdata[0]) begin
          rdop_r <= wdata[1]; al_r <= wdata[3:2]; nack_r <= 1'b0;
          sh_r <= {DEV_ADDR_HI, wdata[3:2], wdata[1], 1'b1, // RL10
                   wdata[1] ? 8'hff : tx_r, 1'b1};
          st_r <= H_START; ph_r <= 2'h0;
        end
        H_START: if (tick) begin
          link.sda_m_o <= 1'b0; link.sda_m_oe <= 1'b1;
          st_r <= H_BITS; ph_r <= 2'h0; bitn_r <= 5'h00;
        end
        H_BITS: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: begin link.scl_m_o <= 1'b0; link.scl_m_oe <= 1'b1; end
            2'h1: begin
              link.sda_m_o <= sh_r[17]; link.sda_m_oe <= !sh_r[17];
            end
            2'h2: begin link.scl_m_o <= 1'b1; link.scl_m_oe <= 1'b0; end
            2'h3: begin
              if (bitn_r == 5'd8 && sda_s_r[1]) nack_r <= 1'b1;
              if (bitn_r == 5'd17 && !rdop_r && sda_s_r[1]) nack_r <= 1'b1;
              if (bitn_r > 5'd8 && bitn_r < 5'd17) rx_r <= {rx_r[6:0], sda_s_r[1]};
              sh_r <= {sh_r[16:0], 1'b1};
              bitn_r <= bitn_r + 5'h01;
              if (bitn_r == 5'd17) st_r <= H_STOP;
            end
          endcase
        end
        H_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          unique case (ph_r)
            2'h0: begin link.scl_m_o <= 1'b0; link.scl_m_oe <= 1'b1; end
            2'h1: begin link.sda_m_o <= 1'b0; link.sda_m_oe <= 1'b1; end
            2'h2: begin link.scl_m_o <= 1'b1; link.scl_m_oe <= 1'b0; end
            2'h3: begin
              link.sda_m_o <= 1'b1; link.sda_m_oe <= 1'b0; st_r <= H_IDLE; // RL11
            end
          endcase
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule

// ===== verification/lnb_link_asserts.sv
module lnb_link_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe
);
  // Ack plus eight low read bits is the longest pull, with margin
  localparam logic [13:0] DRV_MAX = 14'h2710;
  logic [13:0] drv_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drv_r <= 14'h0;
    end else if (sda_d_oe) begin
      drv_r <= drv_r + 14'h1;
    end else begin
      drv_r <= 14'h0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_dev_open_drain: assert property (sda_d_oe |-> !sda_d_o)
    else $error("device drives data line high");
  a_host_sda_open: assert property (sda_m_oe |-> !sda_m_o)
    else $error("host drives data line high");
  a_host_scl_open: assert property (scl_m_oe |-> !scl_m_o)
    else $error("host drives clock line high");
  a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("device changed data while clock high");
  a_start_by_host: assert property ($fell(sda) && scl |-> sda_m_oe && !sda_d_oe)
    else $error("start not made by host alone");
  a_stop_then_idle: assert property ($rose(sda) && scl |=> (scl && sda) [*8])
    else $error("bus not idle high after stop");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> (!scl) [*8])
    else $error("clock low phase too short");
  a_dev_drive_bound: assert property (drv_r <= DRV_MAX)
    else $error("device holds data line low too long");

  c_ack: cover property ($rose(sda_d_oe));
  c_start: cover property ($fell(sda) && scl);
  c_stop: cover property ($rose(sda) && scl);
endmodule

// ===== verification/testbench.sv
module testbench import lnb_ctl_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst_b = 1'b0, pg = 1'b1, rpa = 1'b1, rpb = 1'b1;
  logic [4:0] sta = 5'h00;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, st, v;
  logic wr = 1'b0, rd = 1'b0, ona, onb, tha, thb;
  logic mpa = 1'b0, mpb = 1'b0, tga, tgb, poa, pob;
  logic [1:0] vsa, vsb, tma, tmb;
  logic [2:0] lsa, lsb_o;
  logic [8:0] sh = 9'h0, abyte, dbyte;
  int bitc = 0;
  int error_cnt = 0;
  int n_tests = 0;

  lnb_link_if link();
  lnb_ctl_host i_lnb_ctl_host (.clk(clk), .rst_b(rst_b), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  lnb_ctl_dev i_lnb_ctl_dev (.clk(clk), .rst_b(rst_b), .link(link), .power_good(pg),
    .range_pin_a(rpa), .range_pin_b(rpb), .modulation_pin_a(mpa), .modulation_pin_b(mpb),
    .status_a(sta), .status_b(4'h0), .vout_sel_a(vsa), .vout_sel_b(vsb),
    .channel_a_on(ona), .channel_b_on(onb), .tone_mode_a(tma), .tone_mode_b(tmb),
    .tone_gate_a(tga), .tone_gate_b(tgb), .decoder_threshold_a(tha), .decoder_threshold_b(thb),
    .limit_sel_a(lsa), .limit_sel_b(lsb_o), .power_off_a(poa), .power_off_b(pob));
  lnb_link_asserts i_lnb_link_asserts (.clk(clk), .rst_b(rst_b), .scl(link.scl),
    .sda(link.sda), .scl_m_o(link.scl_m_o), .scl_m_oe(link.scl_m_oe),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe), .sda_d_o(link.sda_d_o),
    .sda_d_oe(link.sda_d_oe));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Wire monitor: bit count restarts at each start, first two bytes with their ack
  always @(negedge link.sda) begin
    if (link.scl) begin
      bitc = 0;
    end
  end
  always @(posedge link.scl) begin
    sh = {sh[7:0], link.sda};
    bitc++;
    if (bitc == 9) begin
      abyte = sh;
    end
    if (bitc == 18) begin
      dbyte = sh;
    end
  end

  task automatic end_sim();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic hr(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask

  // One framed access; a host that stays busy past the limit counts as a mismatch
  task automatic xfer(input logic rw, input logic [1:0] al, input logic [7:0] b);
    int n;
    logic nak;
    n = 0;
    // Address bit two set falls outside the device pattern
    nak = !pg || al[1];
    hw(2'h1, b);
    hw(2'h0, {4'h0, al, rw, 1'b1});
    st = 8'h01;
    while (st[0] && n < 6000) begin
      hr(2'h2, st);
      n++;
    end
    chk("busy", 9'(st[0]), 9'h0);
    chk("addr_ack", abyte, {DEV_ADDR_HI, al, rw, nak});
    chk("nack", 9'(st[1]), 9'(nak));
    if (!rw && !nak) begin
      chk("data_ack", dbyte, {b, 1'b0});
    end
  endtask

  initial begin
    #500000;
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    mpa <= 1'b1;
    mpb <= 1'b1;
    repeat (6) @(posedge clk);
    chk("vout_a", 9'(vsa), 9'(V18_3));
    chk("on_a", 9'(ona), 9'h0);
    chk("tone_a", 9'(tma), 9'(TONE_GATED));
    chk("limit_a", 9'(lsa), 9'(LIM_275));
    chk("gate_a", 9'(tga), 9'h1);
    chk("gate_b", 9'(tgb), 9'h1);
    chk("off_a", 9'(poa), 9'h1);
    chk("off_b", 9'(pob), 9'h1);
    mpa <= 1'b0;
    xfer(1'b0, 2'h1, 8'h72);
    chk("on_a", 9'(ona), 9'h1);
    chk("vout_a", 9'(vsa), 9'(V19_3));
    chk("gate_a", 9'(tga), 9'h0);
    chk("off_a", 9'(poa), 9'h0);
    rpa <= 1'b0;
    repeat (10) @(posedge clk);
    chk("vout_a", 9'(vsa), 9'(V13_3));
    xfer(1'b0, 2'h0, 8'h4e);
    chk("vout_a", 9'(vsa), 9'(V18_3));
    chk("limit_a", 9'(lsa), 9'(LIM_635));
    xfer(1'b0, 2'h1, 8'h34);
    chk("tone_a", 9'(tma), 9'(TONE_CONT));
    chk("thr_a", 9'(tha), 9'h1);
    chk("gate_a", 9'(tga), 9'h1);
    xfer(1'b0, 2'h2, 8'h24);
    chk("tone_a", 9'(tma), 9'(TONE_CONT));
    xfer(1'b0, 2'h0, 8'hac);
    chk("tone_b", 9'(tmb), 9'(TONE_EXT));
    chk("thr_b", 9'(thb), 9'h1);
    chk("gate_b", 9'(tgb), 9'h0);
    xfer(1'b0, 2'h0, 8'hf3);
    chk("on_b", 9'(onb), 9'h1);
    chk("vout_b", 9'(vsb), 9'(V19_3));
    // Status positions written as ones must not stick
    sta <= 5'h15;
    xfer(1'b0, 2'h0, 8'h1f);
    xfer(1'b1, 2'h0, 8'h00);
    hr(2'h3, v);
    chk("read_back", 9'(v), 9'h015);
    chk("off_a", 9'(poa), 9'h1);
    chk("off_b", 9'(pob), 9'h1);
    pg <= 1'b0;
    repeat (10) @(posedge clk);
    xfer(1'b0, 2'h0, 8'h5c);
    chk("limit_a", 9'(lsa), 9'(LIM_635));
    end_sim();
  end
endmodule
